// >>> tmr3_pkg.sv
// Package for the 16-bit timer/counter: register map, fields, reset values.
// Assumes an APB slave with 32-bit data, one register per aligned word.
`default_nettype none
package tmr3_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_COUNT_LOW = 8'h04;
    localparam logic [7:0] OFF_COUNT_HIGH = 8'h08;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] OFF_TRIG_CFG = 8'h14;
    // ------------------------------------------------------------
    // Control and interrupt field positions
    // ------------------------------------------------------------
    localparam int BIT_WIDE_ACCESS = 7;
    localparam int BIT_ASSIGN_HI = 6;
    localparam int BIT_PRESCALE_HI = 5;
    localparam int BIT_PRESCALE_LO = 4;
    localparam int BIT_ASSIGN_LO = 3;
    localparam int BIT_SYNC_DISABLE = 2;
    localparam int BIT_CLOCK_SOURCE = 1;
    localparam int BIT_RUN = 0;
    localparam int BIT_OVERFLOW = 0;
    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hB;
    localparam int PRESCALE_WIDTH = 3;
    localparam int CCP_UNITS = 4;
    typedef enum logic [1:0] {
        TMR3_EXT_WAIT_LOW = 2'b00,
        TMR3_EXT_ARMED = 2'b01
    } tmr3_ext_state_t;
endpackage
`default_nettype wire

// >>> tmr3_edge_qualifier.sv
// Turns the external count input into one-cycle count events.
// Assumes extIn is synchronous to coreClk; sync path adds two flops.
`default_nettype none
module tmr3_edge_qualifier
    import tmr3_pkg::*;
(
    input wire logic coreClk,
    input wire logic nrst,
    input wire logic extIn,
    input wire logic syncDisable,
    input wire logic selected,
    output logic riseEvent
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic sample;
    tmr3_ext_state_t state_reg;

    // ------------------------------------------------------------
    // Optional synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge coreClk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= extIn;
            sync2_reg <= sync1_reg;
        end
    end

    assign sample = syncDisable ? extIn : sync2_reg;

    // ------------------------------------------------------------
    // Rising edges count only after a falling edge was seen
    // ------------------------------------------------------------
    always_ff @(posedge coreClk or negedge nrst) begin
        if (!nrst) begin
            prev_reg <= 1'b0;
            state_reg <= TMR3_EXT_WAIT_LOW;
        end else begin
            prev_reg <= sample;
            if (!selected) begin
                state_reg <= TMR3_EXT_WAIT_LOW;
            end else if (prev_reg && !sample) begin
                state_reg <= TMR3_EXT_ARMED;
            end
        end
    end

    assign riseEvent = selected && (state_reg == TMR3_EXT_ARMED)
        && !prev_reg && sample;
endmodule
`default_nettype wire

// >>> tmr3_timer.sv
// 16-bit timer/counter with prescaler, wide access and APB registers.
// Assumes APB master on coreClk; trigger inputs synchronous to coreClk.
// Behaviour
// - Wide access bit selects 16-bit access
// - Two-bit field assigns timers to capture units
// - Prescaler divides by 1, 2, 4, 8
// - Sync bit matters only for external clock
// - Source select: internal tick or external edges
// - Run bit enables counting, else hold
// - Low read copies high byte to buffer
// - Low write loads buffered high byte
// - Only low-byte writes clear the prescaler
// - Count wraps FFFFh to 0000h, flags overflow
// - Enable gates the overflow interrupt request
// - Special event trigger clears the count
// - Trigger reset unreliable in unsynchronised mode
// - Software write beats trigger reset
// - Trigger reset never sets overflow flag
`default_nettype none
module tmr3_timer
    import tmr3_pkg::*;
#(
    parameter int INT_DIV = 4
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic extCountInput,
    input wire logic [CCP_UNITS-1:0] ccpTrigger,
    input wire logic [4*CCP_UNITS-1:0] compareModeSelect,
    output logic [1:0] ccpTimerAssign,
    output logic irq
);
    import tmr3_pkg::*;

    // Divider register is eight bits wide
    if (INT_DIV < 1 || INT_DIV > 255) begin : gen_bad_div
        $error("INT_DIV out of range");
    end

    logic [7:0] control_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [7:0] highBuf_reg;
    logic [PRESCALE_WIDTH-1:0] presc_reg;
    logic [7:0] intDiv_reg;
    logic status_reg;
    logic enable_reg;
    logic [CCP_UNITS-1:0] trigUse_reg;
    logic access;
    logic wrAcc;
    logic rdAcc;
    logic wrLow;
    logic wrHigh;
    logic wideMode;
    logic intTick;
    logic extEvent;
    logic srcEvent;
    logic countStep;
    logic trigHit;
    logic wrap;
    logic [2:0] divMask;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    function automatic logic known(input logic [7:0] a);
        known = (a == OFF_CONTROL) || (a == OFF_COUNT_LOW)
            || (a == OFF_COUNT_HIGH) || (a == OFF_IRQ_STATUS)
            || (a == OFF_IRQ_ENABLE) || (a == OFF_TRIG_CFG);
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    assign pready = 1'b1;
    assign access = psel && penable;
    assign pslverr = access && !known(paddr);
    assign wrAcc = access && pwrite && pstrb[0] && known(paddr);
    // Reads are taken in setup, so the buffer copy uses the same edge
    assign rdAcc = psel && !penable && !pwrite;
    assign wrLow = wrAcc && hit(paddr, OFF_COUNT_LOW);
    assign wrHigh = wrAcc && hit(paddr, OFF_COUNT_HIGH);
    assign wideMode = control_reg[BIT_WIDE_ACCESS];

    // ------------------------------------------------------------
    // Control and configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            control_reg <= CONTROL_RESET;
        end else if (wrAcc && hit(paddr, OFF_CONTROL)) begin
            control_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            enable_reg <= 1'b0;
            trigUse_reg <= '0;
        end else begin
            if (wrAcc && hit(paddr, OFF_IRQ_ENABLE)) begin
                enable_reg <= pwdata[BIT_OVERFLOW];
            end
            if (wrAcc && hit(paddr, OFF_TRIG_CFG)) begin
                trigUse_reg <= pwdata[CCP_UNITS-1:0];
            end
        end
    end

    // Split field, high part at bit 6 and low part at bit 3
    assign ccpTimerAssign = {control_reg[BIT_ASSIGN_HI],
        control_reg[BIT_ASSIGN_LO]};

    // ------------------------------------------------------------
    // Count source and prescaler
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            intDiv_reg <= 8'h00;
        end else if (intDiv_reg == 8'(INT_DIV - 1)) begin
            intDiv_reg <= 8'h00;
        end else begin
            intDiv_reg <= intDiv_reg + 8'h01;
        end
    end
    assign intTick = (intDiv_reg == 8'(INT_DIV - 1));

    tmr3_edge_qualifier extQual (
        .coreClk(core_clk),
        .nrst(nrst),
        .extIn(extCountInput),
        .syncDisable(control_reg[BIT_SYNC_DISABLE]),
        .selected(control_reg[BIT_CLOCK_SOURCE]),
        .riseEvent(extEvent)
    );

    // Aux oscillator is enabled by the other timer; it arrives here
    // on the same external input.
    assign srcEvent = control_reg[BIT_CLOCK_SOURCE]
        ? extEvent : intTick;

    always_comb begin
        unique case (control_reg[BIT_PRESCALE_HI:BIT_PRESCALE_LO])
            2'b00: divMask = 3'b000;
            2'b01: divMask = 3'b001;
            2'b10: divMask = 3'b011;
            2'b11: divMask = 3'b111;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            presc_reg <= '0;
        end else if (wrLow) begin
            presc_reg <= '0;
        end else if (control_reg[BIT_RUN] && srcEvent) begin
            presc_reg <= presc_reg + 3'd1;
        end
    end

    assign countStep = control_reg[BIT_RUN] && srcEvent
        && ((presc_reg & divMask) == divMask);

    // ------------------------------------------------------------
    // Special event trigger
    // ------------------------------------------------------------
    // Unsynchronised external mode gives no guarantee; the trigger is
    // still applied here, software must not rely on it.
    always_comb begin
        trigHit = 1'b0;
        for (int i = 0; i < CCP_UNITS; i++) begin
            if (trigUse_reg[i] && ccpTrigger[i]
                && compareModeSelect[4*i +: 4] == MODE_SPECIAL_EVENT) begin
                trigHit = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    assign wrap = countStep && (count_reg == COUNT_MAX);

    always_comb begin
        count_next = count_reg;
        if (wrLow) begin
            if (wideMode) begin
                count_next = {highBuf_reg, pwdata[7:0]};
            end else begin
                count_next = {count_reg[15:8], pwdata[7:0]};
            end
        end else if (wrHigh && !wideMode) begin
            count_next = {pwdata[7:0], count_reg[7:0]};
        end else if (trigHit) begin
            count_next = COUNT_RESET;
        end else if (countStep) begin
            count_next = count_reg + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    // High byte buffer, wide mode only: filled by high-byte writes or by low-byte reads
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            highBuf_reg <= 8'h00;
        end else if (wideMode && wrHigh) begin
            highBuf_reg <= pwdata[7:0];
        end else if (wideMode && rdAcc && hit(paddr, OFF_COUNT_LOW)) begin
            highBuf_reg <= count_reg[15:8];
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, set wins over write-one clear
    // ------------------------------------------------------------
    // Wrap is the only setter, a trigger reset never wraps.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            status_reg <= 1'b0;
        end else if (wrap && !wrLow && !(wrHigh && !wideMode)
            && !trigHit) begin
            status_reg <= 1'b1;
        end else if (wrAcc && hit(paddr, OFF_IRQ_STATUS)
            && pwdata[BIT_OVERFLOW]) begin
            status_reg <= 1'b0;
        end
    end

    assign irq = status_reg && enable_reg;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            unique case (paddr)
                OFF_CONTROL: prdata[7:0] <= control_reg;
                OFF_COUNT_LOW: prdata[7:0] <= count_reg[7:0];
                OFF_COUNT_HIGH: prdata[7:0] <= wideMode
                    ? highBuf_reg : count_reg[15:8];
                OFF_IRQ_STATUS: prdata[BIT_OVERFLOW] <= status_reg;
                OFF_IRQ_ENABLE: prdata[BIT_OVERFLOW] <= enable_reg;
                OFF_TRIG_CFG: prdata[CCP_UNITS-1:0] <= trigUse_reg;
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> tmr3_timer_chk.sv
// Checker for the timer's bus, interrupt and assign outputs.
// Assumes it is bound to tmr3_timer and sees only its ports.
`default_nettype none
module tmr3_timer_chk
    import tmr3_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] ccpTimerAssign,
    input wire logic irq
);
    // ----------------------------------------
    // Helpers and properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic acc;
    logic wrCtl;
    logic mapped;
    logic [7:0] ctlShadow;
    assign acc = psel && penable;
    assign wrCtl = acc && pwrite && pstrb[0] && paddr == OFF_CONTROL;
    assign mapped = paddr inside {OFF_CONTROL, OFF_COUNT_LOW, OFF_COUNT_HIGH,
        OFF_IRQ_STATUS, OFF_IRQ_ENABLE, OFF_TRIG_CFG};
    // Shadow lets readback be judged without seeing the body
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) ctlShadow <= CONTROL_RESET;
        else if (wrCtl) ctlShadow <= pwdata[7:0];
    end
    a_ctl_readback: assert property (
        acc && !pwrite && paddr == OFF_CONTROL |-> prdata[7:0] == ctlShadow)
        else $error("control readback");
    a_assign_follows: assert property (wrCtl
        |=> ccpTimerAssign == {$past(pwdata[6]), $past(pwdata[3])})
        else $error("assign field");
    a_assign_holds: assert property (
        !wrCtl |=> $stable(ccpTimerAssign)) else $error("assign changed");
    a_irq_masked: assert property (acc && pwrite && pstrb[0]
        && paddr == OFF_IRQ_ENABLE && !pwdata[0] |=> !irq [*2])
        else $error("irq while masked");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr)
        else $error("no error on unmapped");
    a_err_mapped: assert property (acc && mapped |-> !pslverr)
        else $error("error on mapped");
    a_err_idle: assert property (!acc |-> !pslverr)
        else $error("error outside access");
    a_rd_upper: assert property (
        acc && !pwrite |-> pready && prdata[31:8] == 24'h0)
        else $error("read upper bits");
endmodule
bind tmr3_timer tmr3_timer_chk u_chk (.core_clk(core_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ccpTimerAssign(ccpTimerAssign), .irq(irq));
`default_nettype wire

// >>> tmr3_timer_tb.sv
// Testbench for the 16-bit timer: APB master plus input drive.
// Assumes package, design and checker are compiled first.
`default_nettype none
module tmr3_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tmr3_pkg::*;
    // ----------------------------------------
    // Signals and design
    // ----------------------------------------
    localparam logic [7:0] CT = OFF_CONTROL, LO = OFF_COUNT_LOW;
    localparam logic [7:0] HI = OFF_COUNT_HIGH, ST = OFF_IRQ_STATUS;
    logic core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, ext = 1'b0, trigArm = 1'b0, err, pready;
    logic pslverr, irq;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF, ccpTrigger = 4'h0;
    logic [15:0] modeSel = 16'h000A;
    logic [1:0] ccpTimerAssign;
    int miscompares = 0, cmpCount = 0;
    tmr3_timer #(.INT_DIV(4)) DUT (.core_clk(core_clk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .extCountInput(ext), .ccpTrigger(ccpTrigger),
        .compareModeSelect(modeSel), .ccpTimerAssign(ccpTimerAssign),
        .irq(irq));
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] lo, hi, got);
        cmpCount++;
        if (got !== lo && ($isunknown(got) || got < lo || got > hi)) begin
            $display("wrong value %s expected %0h-%0h seen %0h",
                nm, lo, hi, got);
            miscompares++;
        end
    endtask
    // Trigger rides the access cycle, so it meets the write exactly
    task automatic apb(input logic w, input logic [7:0] a, d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        ccpTrigger <= {3'b0, trigArm};
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        ccpTrigger <= 4'h0;
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge core_clk);
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && cmpCount > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        apb(0, CT, 0);
        chk("ctl", 0, 0, rd);
        for (int i = 0; i < 4; i++) begin
            apb(1, CT, {1'b0, i[1], 2'b0, i[0], 3'b0});
            apb(0, CT, 0);
            chk("assign", i, i, ccpTimerAssign);
        end
        pstrb <= 4'h0;
        apb(1, CT, 8'h08);
        pstrb <= 4'hF;
        apb(0, CT, 0);
        chk("ctl", 8'h48, 8'h48, rd);
        apb(0, 8'h20, 0);
        chk("err", 1, 1, err);
    endtask
    task automatic t_prescale();
        logic [31:0] v;
        for (int p = 0; p < 4; p++) begin
            apb(1, HI, 0);
            apb(1, LO, 0);
            apb(1, CT, {2'b0, p[1:0], 4'h1});
            idle(200);
            apb(1, CT, 0);
            apb(0, LO, 0);
            chk("div", 200 / (4 << p) - 1, 204 / (4 << p) + 1, rd);
        end
        v = rd;
        idle(30);
        apb(0, LO, 0);
        chk("hold", v, v, rd);
    endtask
    task automatic t_wide();
        apb(1, CT, 8'h80);
        apb(1, HI, 8'h12);
        apb(1, LO, 8'h34);
        apb(1, HI, 8'h56);
        apb(0, LO, 0);
        chk("low", 8'h34, 8'h34, rd);
        apb(0, HI, 0);
        chk("buf", 8'h12, 8'h12, rd);
        apb(1, CT, 0);
        apb(0, HI, 0);
        chk("live", 8'h12, 8'h12, rd);
        apb(1, HI, 8'h77);
        apb(1, LO, 8'h01);
        apb(0, HI, 0);
        chk("narrow", 8'h77, 8'h77, rd);
    endtask
    task automatic t_overflow();
        apb(1, HI, 8'hFF);
        apb(1, LO, 8'hF8);
        apb(1, CT, 8'h01);
        idle(60);
        apb(1, CT, 0);
        apb(0, ST, 0);
        chk("flag", 1, 1, rd);
        chk("irq", 0, 0, irq);
        apb(0, HI, 0);
        chk("wrap", 0, 0, rd);
        apb(1, OFF_IRQ_ENABLE, 1);
        apb(0, ST, 0);
        chk("irq", 1, 1, irq);
        apb(1, ST, 1);
        apb(0, ST, 0);
        chk("clear", 0, 0, rd);
        chk("irq", 0, 0, irq);
    endtask
    task automatic t_trigger();
        apb(1, OFF_TRIG_CFG, 1);
        apb(1, HI, 8'hFF);
        apb(1, LO, 8'hFF);
        trigArm = 1'b1;
        apb(0, CT, 0);
        trigArm = 1'b0;
        apb(0, HI, 0);
        chk("mode", 8'hFF, 8'hFF, rd);
        modeSel <= 16'h000B;
        trigArm = 1'b1;
        apb(0, CT, 0);
        trigArm = 1'b0;
        apb(0, HI, 0);
        chk("reset", 0, 0, rd);
        apb(0, ST, 0);
        chk("flag", 0, 0, rd);
        apb(1, HI, 8'h21);
        trigArm = 1'b1;
        apb(1, LO, 8'h55);
        trigArm = 1'b0;
        apb(0, LO, 0);
        chk("wins", 8'h55, 8'h55, rd);
    endtask
    task automatic t_external();
        for (int s = 0; s < 2; s++) begin
            ext <= 1'b1;
            apb(1, HI, 0);
            apb(1, LO, 0);
            apb(1, CT, {5'h0, s[0], 2'b11});
            idle(4);
            repeat (5) begin
                ext <= 1'b0;
                idle(4);
                ext <= 1'b1;
                idle(4);
            end
            idle(6);
            apb(1, CT, 0);
            apb(0, LO, 0);
            chk("edges", 5, 5, rd);
        end
    endtask
    initial begin
        idle(16);
        nrst <= 1'b1;
        t_regs();
        t_prescale();
        t_wide();
        t_overflow();
        t_trigger();
        t_external();
        tally_and_finish();
    end
    initial begin
        idle(20000);
        miscompares++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
